// ==== core/aem_alert_enable.sv ====
// How it works
// R1 - a set non-reserved enable bit lets its summary status bit raise the alert flag, a clear one blocks it.
// R2 - the enables never touch the summary status itself, only the path to the alert flag.
// R3 - the alert flag is set only when a masked bit (status AND enable) goes from 0 to 1.
// R4 - an enable going 0 to 1 over an already set status bit counts as a new assertion.
// R5 - the enable register is read and written from the register bus and from the I2C slave.
// R6 - a register bus write in the same cycle as an I2C write wins and the I2C write is dropped.
// R7 - the four register bytes sit at I2C peripheral addresses 0x84 to 0x87.
// R8 - the enable register resets to all ones.
// R9 - reserved bits 10:12 and 16:23 reset to one, read back as written, and never gate alerts.
// R10 - bits use big-endian order: bit 0 reset event, 1..3 software status 2..0, 4 outbox, 5 inbox.
// R11 - bit 6 I2C block, 7 bus error, 8 and 9 chip summaries, 13..15 logic_layer_event, latency, multicast.
// R12 - bits 24 to 31 gate port events 7 down to 0.
// R13 - the alert flag clears whenever every masked status bit is zero.
// R14 - the alert flag clears when the alert response address is answered, until a new rise.
// R15 - the slave answers the alert response address only while alert_response_enable is set.
// R16 - rising edges are found against a registered copy of status AND enable on the core clock.
`default_nettype none

`include "aem_params.svh"

module aem_alert_enable
	import aem_pkg::*;
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic [16:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	input wire logic [31:0] SUMMARY_STATUS,
	input wire logic ALERT_RESPONSE_ENABLE,
	output logic [31:0] ALERT_SOURCE_ENABLE,
	output logic ALERT_PENDING,
	input wire logic I2C_CLK,
	input wire logic [7:0] I2C_ADDR,
	input wire logic I2C_WR,
	input wire logic [7:0] I2C_WDATA,
	input wire logic I2C_RD,
	output logic [7:0] I2C_RDATA,
	output logic I2C_WR_BUSY,
	input wire logic I2C_ARA_DONE,
	output logic I2C_ARA_RESPOND
);

	// ==========================================================
	// helpers

	// R7 byte window
	function automatic logic pa_hit(input logic [7:0] pa);
		pa_hit = (pa >= `AEM_PA_FIRST) && (pa <= `AEM_PA_LAST);
	endfunction

	// lane 0 (0x84) is the low byte of the word
	function automatic aem_word_t merge_byte(
		input aem_word_t word,
		input logic [1:0] lane,
		input logic [7:0] data
	);
		aem_word_t res;
		res = word;
		res[lane * 8 +: 8] = data;
		merge_byte = res;
	endfunction

	function automatic logic [7:0] pick_byte(
		input aem_word_t word,
		input logic [1:0] lane
	);
		pick_byte = word[lane * 8 +: 8];
	endfunction

	// ==========================================================
	// declarations

	aem_word_t enable;
	aem_word_t masked;
	aem_word_t masked_prev;
	logic rise;
	logic reg_wr_hit;
	logic reg_rd_hit;

	// link write crossing
	aem_lwr_e lwr_state;
	logic lwr_req;
	logic [1:0] lwr_lane;
	logic [7:0] lwr_byte;
	logic lwr_req_c1;
	logic lwr_req_c2;
	logic lwr_ack;
	logic lwr_ack_l1;
	logic lwr_ack_l2;
	logic lwr_event;

	// core to link mirror crossing
	aem_mir_e mir_state;
	aem_word_t mir_data;
	logic mir_req;
	logic mir_req_l1;
	logic mir_req_l2;
	logic mir_ack;
	logic mir_ack_c1;
	logic mir_ack_c2;
	aem_word_t shadow;

	// alert response crossing
	logic ara_tgl;
	logic ara_c1;
	logic ara_c2;
	logic ara_c3;
	logic ara_event;
	logic ara_arm;
	logic ara_l1;

	// ==========================================================
	// register bus decode

	always_comb
	begin
		reg_wr_hit = REG_WR && (REG_ADDR == `AEM_OFS_ALERT_SOURCE_ENABLE);
		reg_rd_hit = REG_RD && (REG_ADDR == `AEM_OFS_ALERT_SOURCE_ENABLE);
	end

	// ==========================================================
	// enable register

	assign lwr_event = lwr_req_c2 ^ lwr_ack;

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
			// R8 all ones
			// R9 reserved start set
			enable <= `AEM_RST_ALERT_SOURCE_ENABLE;
		else if (reg_wr_hit)
			// R5 bus write
			// R6 bus wins
			enable <= REG_WDATA;
		else if (lwr_event)
			// R5 I2C write
			enable <= merge_byte(enable, lwr_lane, lwr_byte);
	end

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
			ALERT_SOURCE_ENABLE <= `AEM_RST_ALERT_SOURCE_ENABLE;
		else if (reg_wr_hit)
			ALERT_SOURCE_ENABLE <= REG_WDATA;
		else if (lwr_event)
			ALERT_SOURCE_ENABLE <= merge_byte(enable, lwr_lane, lwr_byte);
	end

	// unmapped reads answer zero
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
			REG_RDATA <= 32'h00000000;
		else if (reg_rd_hit)
			// R9 reserved read back
			REG_RDATA <= enable;
		else if (REG_RD)
			REG_RDATA <= 32'h00000000;
	end

	// ==========================================================
	// alert flag

	// R1 per bit gate
	// R10 positions in word
	// R11 positions in word
	// R12 port order
	// R9 reserved ignored
	// R2 status only read
	assign masked = SUMMARY_STATUS & enable & ~`AEM_RESERVED_MASK;

	// R16 previous masked copy
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
			masked_prev <= 32'h00000000;
		else
			masked_prev <= masked;
	end

	// R3 rising edge only
	// R4 enable rise counts
	assign rise = |(masked & ~masked_prev);

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
			ALERT_PENDING <= 1'b0;
		else if (rise)
			ALERT_PENDING <= 1'b1;
		// R13 all masked zero
		else if (masked == 32'h00000000)
			ALERT_PENDING <= 1'b0;
		// R14 cleared by answer
		else if (ara_event)
			ALERT_PENDING <= 1'b0;
	end

	// R15 respond only enabled
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
			ara_arm <= 1'b0;
		else
			ara_arm <= ALERT_PENDING && ALERT_RESPONSE_ENABLE && !ara_event;
	end

	// ==========================================================
	// core side synchronisers

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			lwr_req_c1 <= 1'b0;
			lwr_req_c2 <= 1'b0;
			lwr_ack <= 1'b0;
		end
		else
		begin
			lwr_req_c1 <= lwr_req;
			lwr_req_c2 <= lwr_req_c1;
			lwr_ack <= lwr_req_c2;
		end
	end

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			ara_c1 <= 1'b0;
			ara_c2 <= 1'b0;
			ara_c3 <= 1'b0;
		end
		else
		begin
			ara_c1 <= ara_tgl;
			ara_c2 <= ara_c1;
			ara_c3 <= ara_c2;
		end
	end

	assign ara_event = ara_c2 ^ ara_c3;

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			mir_ack_c1 <= 1'b0;
			mir_ack_c2 <= 1'b0;
		end
		else
		begin
			mir_ack_c1 <= mir_ack;
			mir_ack_c2 <= mir_ack_c1;
		end
	end

	// ==========================================================
	// mirror of the enable register towards the link

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			mir_state <= AEM_MIR_IDLE;
			mir_data <= `AEM_RST_ALERT_SOURCE_ENABLE;
			mir_req <= 1'b0;
		end
		else
		begin
			case (mir_state)
				AEM_MIR_IDLE:
				begin
					if (mir_data != enable)
					begin
						mir_data <= enable;
						mir_req <= ~mir_req;
						mir_state <= AEM_MIR_WAIT;
					end
				end
				AEM_MIR_WAIT:
				begin
					if (mir_ack_c2 == mir_req)
						mir_state <= AEM_MIR_IDLE;
				end
				default:
					mir_state <= AEM_MIR_IDLE;
			endcase
		end
	end

	// ==========================================================
	// link domain: mirror receive

	always_ff @(posedge I2C_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			mir_req_l1 <= 1'b0;
			mir_req_l2 <= 1'b0;
			mir_ack <= 1'b0;
		end
		else
		begin
			mir_req_l1 <= mir_req;
			mir_req_l2 <= mir_req_l1;
			mir_ack <= mir_req_l2;
		end
	end

	// mir_data is held stable until the ack returns
	always_ff @(posedge I2C_CLK or negedge NRST)
	begin
		if (!NRST)
			shadow <= `AEM_RST_ALERT_SOURCE_ENABLE;
		else if (mir_req_l2 != mir_ack)
			shadow <= mir_data;
	end

	// ==========================================================
	// link domain: byte reads

	always_ff @(posedge I2C_CLK or negedge NRST)
	begin
		if (!NRST)
			I2C_RDATA <= 8'h00;
		else if (I2C_RD && pa_hit(I2C_ADDR))
			// R5 I2C read
			// R7 byte select
			I2C_RDATA <= pick_byte(shadow, I2C_ADDR[1:0]);
		else if (I2C_RD)
			I2C_RDATA <= 8'h00;
	end

	// ==========================================================
	// link domain: byte writes

	always_ff @(posedge I2C_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			lwr_ack_l1 <= 1'b0;
			lwr_ack_l2 <= 1'b0;
		end
		else
		begin
			lwr_ack_l1 <= lwr_ack;
			lwr_ack_l2 <= lwr_ack_l1;
		end
	end

	// a write that arrives while busy is dropped
	always_ff @(posedge I2C_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			lwr_state <= AEM_LWR_IDLE;
			lwr_req <= 1'b0;
			lwr_lane <= 2'h0;
			lwr_byte <= 8'h00;
			I2C_WR_BUSY <= 1'b0;
		end
		else
		begin
			case (lwr_state)
				AEM_LWR_IDLE:
				begin
					// R7 byte window
					if (I2C_WR && pa_hit(I2C_ADDR))
					begin
						lwr_lane <= I2C_ADDR[1:0];
						lwr_byte <= I2C_WDATA;
						lwr_req <= ~lwr_req;
						lwr_state <= AEM_LWR_WAIT;
						I2C_WR_BUSY <= 1'b1;
					end
				end
				AEM_LWR_WAIT:
				begin
					if (lwr_ack_l2 == lwr_req)
					begin
						lwr_state <= AEM_LWR_IDLE;
						I2C_WR_BUSY <= 1'b0;
					end
				end
				default:
				begin
					lwr_state <= AEM_LWR_IDLE;
					I2C_WR_BUSY <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// link domain: alert response address

	always_ff @(posedge I2C_CLK or negedge NRST)
	begin
		if (!NRST)
			ara_tgl <= 1'b0;
		else if (I2C_ARA_DONE)
			// R14 answer reported
			ara_tgl <= ~ara_tgl;
	end

	always_ff @(posedge I2C_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			ara_l1 <= 1'b0;
			I2C_ARA_RESPOND <= 1'b0;
		end
		else
		begin
			ara_l1 <= ara_arm;
			// R15 gated respond
			I2C_ARA_RESPOND <= ara_l1;
		end
	end

endmodule

`default_nettype wire

// ==== core/aem_params.svh ====
`ifndef AEM_PARAMS_SVH
`define AEM_PARAMS_SVH

// ==========================================================
// register map on the internal register bus
`define AEM_OFS_ALERT_SOURCE_ENABLE 17'h1d284
`define AEM_RST_ALERT_SOURCE_ENABLE 32'hffffffff

// ==========================================================
// byte window seen by the external management master
`define AEM_PA_FIRST 8'h84
`define AEM_PA_LAST 8'h87

// ==========================================================
// reserved enable positions (big-endian bits 10:12 and 16:23)
`define AEM_RESERVED_MASK 32'h0038ff00

`endif

// ==== core/aem_pkg.sv ====
`default_nettype none

package aem_pkg;

	typedef logic [31:0] aem_word_t;

	// core side of the mirror handshake towards the link
	typedef enum logic [0:0]
	{
		AEM_MIR_IDLE = 1'b0,
		AEM_MIR_WAIT = 1'b1
	} aem_mir_e;

	// link side of the byte write handshake towards the core
	typedef enum logic [0:0]
	{
		AEM_LWR_IDLE = 1'b0,
		AEM_LWR_WAIT = 1'b1
	} aem_lwr_e;

endpackage

`default_nettype wire

// ==== testbench/aem_alert_enable_props.sv ====
`default_nettype none
`include "aem_params.svh"
module aem_alert_enable_props
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic [16:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_WDATA,
	input wire logic [31:0] REG_RDATA,
	input wire logic [31:0] SUMMARY_STATUS,
	input wire logic ALERT_RESPONSE_ENABLE,
	input wire logic [31:0] ALERT_SOURCE_ENABLE,
	input wire logic ALERT_PENDING,
	input wire logic I2C_CLK,
	input wire logic [7:0] I2C_ADDR,
	input wire logic I2C_WR,
	input wire logic I2C_WR_BUSY,
	input wire logic I2C_ARA_RESPOND
);
	timeunit 1ns;
	timeprecision 100ps;
	// ====================
	// masked status history
	wire logic [31:0] m = SUMMARY_STATUS & ALERT_SOURCE_ENABLE
		& ~`AEM_RESERVED_MASK;
	logic [31:0] prev;
	wire logic rise = |(m & ~prev);
	always_ff @(posedge CLOCK or negedge NRST)
		if (!NRST)
			prev <= '0;
		else
			prev <= m;
	sequence bus_wr;
		REG_WR && REG_ADDR == `AEM_OFS_ALERT_SOURCE_ENABLE;
	endsequence
	sequence bus_rd;
		REG_RD && REG_ADDR == `AEM_OFS_ALERT_SOURCE_ENABLE;
	endsequence
	pend_set_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		rise |=> ALERT_PENDING) else $error("pending not set");
	pend_clear_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		m == 0 |=> !ALERT_PENDING) else $error("pending not cleared");
	pend_cause_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		$rose(ALERT_PENDING) |-> $past(rise)) else $error("pending unasked");
	bus_write_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		bus_wr |=> ALERT_SOURCE_ENABLE == $past(REG_WDATA))
		else $error("bus write lost");
	bus_read_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		bus_rd |=> REG_RDATA == $past(ALERT_SOURCE_ENABLE))
		else $error("bus read wrong");
	unmapped_read_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		REG_RD && REG_ADDR != `AEM_OFS_ALERT_SOURCE_ENABLE |=> REG_RDATA == 0)
		else $error("unmapped read not zero");
	ara_gate_a: assert property (@(posedge I2C_CLK) disable iff (!NRST)
		$rose(I2C_ARA_RESPOND) |-> ALERT_RESPONSE_ENABLE)
		else $error("respond while disabled");
	link_busy_a: assert property (@(posedge I2C_CLK) disable iff (!NRST)
		I2C_WR && !I2C_WR_BUSY && I2C_ADDR >= `AEM_PA_FIRST
		&& I2C_ADDR <= `AEM_PA_LAST |=> I2C_WR_BUSY) else $error("write ignored");
endmodule
bind aem_alert_enable aem_alert_enable_props aem_alert_enable_props_i (.CLOCK,
	.NRST, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA,
	.SUMMARY_STATUS, .ALERT_RESPONSE_ENABLE, .ALERT_SOURCE_ENABLE,
	.ALERT_PENDING, .I2C_CLK, .I2C_ADDR, .I2C_WR, .I2C_WR_BUSY,
	.I2C_ARA_RESPOND);
`default_nettype wire

// ==== testbench/aem_i2c_master.sv ====
`default_nettype none
module aem_i2c_master
(
	input wire logic clk,
	output var logic [7:0] addr,
	output var logic wr,
	output var logic [7:0] wdata,
	output var logic rd,
	input wire logic [7:0] rdata,
	input wire logic busy,
	output var logic ara,
	input wire logic resp
);
	timeunit 1ns;
	timeprecision 100ps;
	int hung = 0;
	initial
	begin
		{addr, wdata} = 16'h0000;
		{wr, rd, ara} = 3'h0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic settle;
		int n = 0;
		while (busy !== 1'b0 && n < 200)
		begin
			step(1);
			n++;
		end
		if (busy !== 1'b0)
			hung++;
	endtask
	// released lines show the inverse of the last value
	task automatic put(input logic [7:0] a, input logic [7:0] v);
		step(1);
		settle();
		{addr, wdata, wr} = {a, v, 1'b1};
		step(1);
		{addr, wdata, wr} = {~addr, ~wdata, 1'b0};
		settle();
	endtask
	task automatic get(input logic [7:0] a, output logic [7:0] v);
		step(1);
		{addr, rd} = {a, 1'b1};
		step(1);
		{addr, rd} = {~addr, 1'b0};
		v = rdata;
	endtask
	task automatic answer;
		int n = 0;
		step(1);
		while (resp !== 1'b1 && n < 200)
		begin
			step(1);
			n++;
		end
		if (resp !== 1'b1)
			hung++;
		ara = 1;
		step(1);
		ara = 0;
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`default_nettype none
`include "aem_params.svh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [16:0] OFS = `AEM_OFS_ALERT_SOURCE_ENABLE;
	localparam logic [31:0] RSV = `AEM_RESERVED_MASK;
	logic clk = 0, ick = 0, nrst = 0, wr = 0, rd = 0, are = 0;
	logic [16:0] addr = '0;
	logic [31:0] wdata = '0, st = '0, rdata, ase, d;
	logic pend, iwr, ird, busy, ara, resp;
	logic [7:0] iaddr, iwd, irdata, b;
	int err_total = 0, n_checks = 0, t = 0;
	always #25 clk = ~clk;
	always #3 ick = ~ick;
	aem_alert_enable aem_alert_enable_i (.CLOCK(clk), .NRST(nrst),
		.REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
		.REG_RDATA(rdata), .SUMMARY_STATUS(st),
		.ALERT_RESPONSE_ENABLE(are), .ALERT_SOURCE_ENABLE(ase),
		.ALERT_PENDING(pend), .I2C_CLK(ick), .I2C_ADDR(iaddr),
		.I2C_WR(iwr), .I2C_WDATA(iwd), .I2C_RD(ird), .I2C_RDATA(irdata),
		.I2C_WR_BUSY(busy), .I2C_ARA_DONE(ara), .I2C_ARA_RESPOND(resp));
	aem_i2c_master aem_i2c_master_i (.clk(ick), .addr(iaddr), .wr(iwr),
		.wdata(iwd), .rd(ird), .rdata(irdata), .busy(busy), .ara(ara),
		.resp(resp));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cp(input logic e);
		chk({31'h0, pend}, {31'h0, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bw(input logic [16:0] a, input logic [31:0] v);
		cyc(1);
		{addr, wdata, wr} = {a, v, 1'b1};
		cyc(1);
		wr = 0;
	endtask
	task automatic br(input logic [16:0] a);
		cyc(1);
		{addr, rd} = {a, 1'b1};
		cyc(1);
		rd = 0;
		d = rdata;
	endtask
	task automatic fin;
		t++;
		$display("test %0d done", t);
	endtask
	task automatic conclude;
		err_total += aem_i2c_master_i.hung;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#2000000;
		err_total++;
		conclude();
	end
	initial
	begin
		cyc(10);
		chk(ase, 32'hffffffff);
		nrst = 1;
		br(OFS);
		chk(d, 32'hffffffff);
		br(OFS + 17'h4);
		chk(d, 32'h0);
		bw(OFS + 17'h4, 32'h0);
		chk(ase, 32'hffffffff);
		fin();
		bw(OFS, RSV);
		br(OFS);
		chk(d, RSV);
		st = '1;
		cyc(2);
		cp(0);
		st = '0;
		fin();
		for (int i = 0; i < 32; i++)
			if (!RSV[i])
			begin
				bw(OFS, 32'h1 << i);
				st = ~(32'h1 << i);
				cyc(1);
				cp(0);
				st = '1;
				cyc(1);
				cp(1);
				st = '0;
				cyc(1);
				cp(0);
			end
		fin();
		bw(OFS, '1);
		st = 32'h80000000;
		cyc(1);
		cp(1);
		cyc(10);
		chk({31'h0, resp}, 32'h0);
		are = 1;
		aem_i2c_master_i.answer();
		cyc(4);
		cp(0);
		cyc(10);
		cp(0);
		{are, st} = 33'h0;
		fin();
		bw(OFS, '0);
		st = 32'h1;
		cyc(3);
		cp(0);
		bw(OFS, 32'h1);
		cyc(1);
		cp(1);
		st = '0;
		fin();
		for (int k = 1; k < 5; k++)
			aem_i2c_master_i.put(8'h83 + k[7:0], 8'h11 * k[7:0]);
		aem_i2c_master_i.put(8'h88, 8'hee);
		cyc(8);
		chk(ase, 32'h44332211);
		aem_i2c_master_i.get(8'h86, b);
		chk({24'h0, b}, 32'h33);
		aem_i2c_master_i.get(8'h87, b);
		chk({24'h0, b}, 32'h44);
		aem_i2c_master_i.get(8'h88, b);
		chk({24'h0, b}, 32'h0);
		fin();
		fork
			begin
				cyc(1);
				{addr, wdata, wr} = {OFS, 32'h5a5a5a5a, 1'b1};
				for (int j = 0; j < 40; j++)
				begin
					cyc(1);
					chk(ase, 32'h5a5a5a5a);
				end
				wr = 0;
			end
			begin
				cyc(2);
				aem_i2c_master_i.put(8'h84, 8'h00);
			end
		join
		cyc(8);
		chk(ase, 32'h5a5a5a5a);
		fin();
		conclude();
	end
endmodule
`default_nettype wire
